// [src/cpt_defs.svh]
/*
 * Register map, field positions, reset values and period counts of the
 * clock and time-base unit.
 * Assumes inclusion by bare name from the unit's design files.
 */
`ifndef CPT_DEFS_SVH
`define CPT_DEFS_SVH

// register indices, byte address is four times the index
`define CPT_IDX_CTRL 8'h2E
`define CPT_IDX_STAT 8'h31
`define CPT_IDX_MASK 8'h32
`define CPT_ADDR_CTRL {`CPT_IDX_CTRL, 2'h0}
`define CPT_ADDR_STAT {`CPT_IDX_STAT, 2'h0}
`define CPT_ADDR_MASK {`CPT_IDX_MASK, 2'h0}

// clock_timebase_control_status fields
`define CPT_BIT_CLKOUT 7
`define CPT_BIT_DIV_HI 6
`define CPT_BIT_DIV_LO 5
`define CPT_BIT_SLOW 4
`define CPT_BIT_TB_HI 3
`define CPT_BIT_TB_LO 2
`define CPT_BIT_IRQEN 1
`define CPT_BIT_FLAG 0
`define CPT_CTRL_RESET 8'h00
`define CPT_EVT_RESET 1'h0

// time-base periods in oscillator cycles
`define CPT_TB_PERIOD0 18'h03E80
`define CPT_TB_PERIOD1 18'h07D00
`define CPT_TB_PERIOD2 18'h13880
`define CPT_TB_PERIOD3 18'h30D40

`define CPT_RESP_OKAY 2'h0
`define CPT_RESP_SLVERR 2'h2

`endif

// [src/cpt_pkg.sv]
/*
 * Types shared by the clock and time-base unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cpt_pkg;
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_WAIT,
        PWR_AHALT,
        PWR_HALT
    } cpt_pwr_e;
    typedef logic [17:0] cpt_period_t;
endpackage

// [src/cpt_tb_if.sv]
/*
 * Link between the register logic and the time-base counter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cpt_tb_if;
    logic [1:0] sel;
    logic run;
    logic tick;
    modport ctl (output sel, output run, input tick);
    modport cnt (input sel, input run, output tick);
endinterface

// [src/cpt_cpu_divider.sv]
/*
 * CPU clock enable generator: full rate or oscillator / 2,4,8,16.
 * Assumes clk is the oscillator clock and rstN a synchronised reset.
 */
`timescale 1ns/1ps
module cpt_cpu_divider (
    input wire logic clk, // oscillator clock
    input wire logic rstN, // synchronised reset, active low
    input wire logic run, // low freezes the CPU clock
    input wire logic slowSel, // slow mode select
    input wire logic [1:0] divSel, // slow divider select
    output logic cpuClkEn // one cycle per CPU clock
);
    logic [3:0] cnt_q;
    logic [3:0] mask;

    assign mask = 4'((5'h2 << divSel) - 5'h1);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt_q <= 4'h0;
        end else if (run) begin
            cnt_q <= 4'(cnt_q + 4'h1);
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cpuClkEn <= 1'h0;
        end else begin
            cpuClkEn <= run && (!slowSel || ((cnt_q & mask) == mask));
        end
    end

    chk_normal_speed: assert property (
        @(posedge clk) disable iff (!rstN)
        (run && !slowSel) |=> cpuClkEn)
        else $error("cpu clock not undivided in normal mode");

    chk_slow_div4: assert property (
        @(posedge clk) disable iff (!rstN)
        (cpuClkEn && run && slowSel && divSel == 2'h1 &&
         $past(slowSel) && $past(divSel) == 2'h1) |=>
        (!cpuClkEn || !run || !slowSel || divSel != 2'h1) [*3])
        else $error("cpu clock enable faster than divide by four");
endmodule

// [src/cpt_timebase_counter.sv]
/*
 * Time-base counter: counts oscillator cycles, pulses tick each period.
 * Assumes the selection arrives from the register logic on the same clock.
 */
`timescale 1ns/1ps
`include "cpt_defs.svh"
module cpt_timebase_counter #(
    parameter cpt_pkg::cpt_period_t TB_PERIOD0 = `CPT_TB_PERIOD0, // code 00
    parameter cpt_pkg::cpt_period_t TB_PERIOD1 = `CPT_TB_PERIOD1, // code 01
    parameter cpt_pkg::cpt_period_t TB_PERIOD2 = `CPT_TB_PERIOD2, // code 10
    parameter cpt_pkg::cpt_period_t TB_PERIOD3 = `CPT_TB_PERIOD3 // code 11
) (
    input wire logic clk, // oscillator clock
    input wire logic rstN, // synchronised reset, active low
    cpt_tb_if.cnt tb // selection, run and tick
);
    cpt_pkg::cpt_period_t cnt_q;
    cpt_pkg::cpt_period_t period;
    logic [1:0] curSel_q;
    logic last;
    logic tick_q;

    always_comb begin
        case (curSel_q)
            2'h0: period = TB_PERIOD0;
            2'h1: period = TB_PERIOD1;
            2'h2: period = TB_PERIOD2;
            default: period = TB_PERIOD3;
        endcase
    end

    assign last = cnt_q == 18'(period - 18'h1);
    assign tb.tick = tick_q;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt_q <= 18'h0;
        end else if (tb.run) begin
            cnt_q <= last ? 18'h0 : 18'(cnt_q + 18'h1);
        end
    end

    // new selection only at a period boundary
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            curSel_q <= 2'h0;
        end else if (tb.run && last) begin
            curSel_q <= tb.sel;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            tick_q <= 1'h0;
        end else begin
            tick_q <= tb.run && last;
        end
    end

    chk_sel_boundary: assert property (
        @(posedge clk) disable iff (!rstN)
        !(tb.run && last) |=> $stable(curSel_q))
        else $error("time base changed inside a period");

    chk_period_wrap: assert property (
        @(posedge clk) disable iff (!rstN)
        (tb.run && last) |=> (tick_q && cnt_q == 18'h0))
        else $error("counter did not restart at period end");

    chk_period_len: assert property (
        @(posedge clk) disable iff (!rstN)
        (tb.run && curSel_q == 2'h0 && cnt_q == 18'h03E7F) |=> tick_q)
        else $error("shortest period not 16000 cycles");
endmodule

// [src/cpt_clock_timebase.sv]
/*
 * Clock and time-base unit: CPU clock prescaler, oscillator clock out on a
 * pin, real-time time base with flag and interrupt, AXI4-Lite registers.
 * Assumes mclk is the oscillator clock and the CPU signals halt and wait
 * instructions on mclk; the external wake-up comes from outside.
 */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cpt_defs.svh"
module cpt_clock_timebase #(
    parameter cpt_pkg::cpt_period_t TB_PERIOD0 = `CPT_TB_PERIOD0, // code 00
    parameter cpt_pkg::cpt_period_t TB_PERIOD1 = `CPT_TB_PERIOD1, // code 01
    parameter cpt_pkg::cpt_period_t TB_PERIOD2 = `CPT_TB_PERIOD2, // code 10
    parameter cpt_pkg::cpt_period_t TB_PERIOD3 = `CPT_TB_PERIOD3 // code 11
) (
    input wire logic mclk, // oscillator clock, 40 MHz
    input wire logic nrst, // asynchronous reset, active low
    input wire logic [9:0] awaddr, // write address
    input wire logic [2:0] awprot, // write protection, unused
    input wire logic awvalid, // write address valid
    output logic awready, // write address ready
    input wire logic [31:0] wdata, // write data
    input wire logic [3:0] wstrb, // write byte strobes
    input wire logic wvalid, // write data valid
    output logic wready, // write data ready
    output logic [1:0] bresp, // write response
    output logic bvalid, // write response valid
    input wire logic bready, // write response ready
    input wire logic [9:0] araddr, // read address
    input wire logic [2:0] arprot, // read protection, unused
    input wire logic arvalid, // read address valid
    output logic arready, // read address ready
    output logic [31:0] rdata, // read data
    output logic [1:0] rresp, // read response
    output logic rvalid, // read data valid
    input wire logic rready, // read data ready
    input wire logic haltExec, // halt instruction executed, pulse
    input wire logic waitExec, // wait instruction executed, pulse
    input wire logic wakeExt, // halt-exiting interrupt, asynchronous
    input wire logic gpioO, // port data when pin is plain I/O
    input wire logic gpioOe, // port enable when pin is plain I/O
    output logic clkOutPinO, // clock-out pin output value
    output logic clkOutPinOe, // clock-out pin output enable
    output logic cpuClkEn, // CPU clock enable, one per CPU cycle
    output logic tbIrq, // time-base interrupt request, level
    output logic irq, // masked event interrupt, level
    output logic activeHalt, // device in active halt
    output logic haltMode // device in halt
);
    logic [1:0] rstSync_q;
    logic rstN;
    logic [1:0] wakeSync_q;
    logic wakeS;
    cpt_pkg::cpt_pwr_e pwr_q;
    logic freezeReg;
    logic [7:1] swBits_q;
    logic flag_q;
    logic [7:0] ctrlReg;
    logic evt_q;
    logic mask_q;
    logic wrFire;
    logic rdFire;
    logic wrCtrl;
    logic rdCtrl;
    logic rdStat;
    logic rdHit;
    logic wrHit;
    logic [31:0] rdMux;
    logic tick;

    cpt_tb_if tbIf();

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'h1};
        end
    end
    assign rstN = rstSync_q[1];

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            wakeSync_q <= 2'h0;
        end else begin
            wakeSync_q <= {wakeSync_q[0], wakeExt};
        end
    end
    assign wakeS = wakeSync_q[1];

    // power mode of the device as seen by this unit
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pwr_q <= cpt_pkg::PWR_RUN;
        end else begin
            case (pwr_q)
                cpt_pkg::PWR_RUN: begin
                    if (haltExec) begin
                        pwr_q <= ctrlReg[`CPT_BIT_IRQEN] ?
                            cpt_pkg::PWR_AHALT : cpt_pkg::PWR_HALT;
                    end else if (waitExec) begin
                        pwr_q <= cpt_pkg::PWR_WAIT;
                    end
                end
                cpt_pkg::PWR_WAIT, cpt_pkg::PWR_AHALT: begin
                    if (tbIrq || wakeS) begin
                        pwr_q <= cpt_pkg::PWR_RUN;
                    end
                end
                cpt_pkg::PWR_HALT: begin
                    if (wakeS) begin
                        pwr_q <= cpt_pkg::PWR_RUN;
                    end
                end
                default: pwr_q <= cpt_pkg::PWR_RUN;
            endcase
        end
    end

    assign freezeReg = pwr_q == cpt_pkg::PWR_AHALT ||
        pwr_q == cpt_pkg::PWR_HALT;
    assign activeHalt = pwr_q == cpt_pkg::PWR_AHALT;
    assign haltMode = pwr_q == cpt_pkg::PWR_HALT;

    // both address and data must be offered before the write is taken
    assign wrFire = awvalid && wvalid && !bvalid;
    assign awready = wrFire;
    assign wready = wrFire;
    assign rdFire = arvalid && !rvalid;
    assign arready = !rvalid;
    assign wrCtrl = wrFire && awaddr == `CPT_ADDR_CTRL && wstrb[0];
    assign rdCtrl = rdFire && araddr == `CPT_ADDR_CTRL;
    assign rdStat = rdFire && araddr == `CPT_ADDR_STAT;
    assign wrHit = awaddr == `CPT_ADDR_CTRL || awaddr == `CPT_ADDR_MASK;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            swBits_q <= 7'(`CPT_CTRL_RESET >> 1);
        end else if (wrCtrl && !freezeReg) begin
            swBits_q <= wdata[7:1];
        end
    end

    // a period end in the same cycle as the clearing read wins
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            flag_q <= 1'h0;
        end else if (tick) begin
            flag_q <= 1'h1;
        end else if (rdCtrl && !freezeReg) begin
            flag_q <= 1'h0;
        end
    end

    assign ctrlReg = {swBits_q, flag_q};

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            evt_q <= `CPT_EVT_RESET;
        end else if (tick) begin
            evt_q <= 1'h1;
        end else if (rdStat) begin
            evt_q <= 1'h0;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            mask_q <= 1'h0;
        end else if (wrFire && awaddr == `CPT_ADDR_MASK && wstrb[0]) begin
            mask_q <= wdata[0];
        end
    end

    assign irq = evt_q && mask_q;
    assign tbIrq = ctrlReg[`CPT_BIT_IRQEN] && flag_q;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            bvalid <= 1'h0;
            bresp <= `CPT_RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'h1;
            bresp <= wrHit ? `CPT_RESP_OKAY : `CPT_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'h0;
        end
    end

    always_comb begin
        rdMux = 32'h0;
        rdHit = 1'h1;
        case (araddr)
            `CPT_ADDR_CTRL: rdMux = {24'h0, ctrlReg};
            `CPT_ADDR_STAT: rdMux = {31'h0, evt_q};
            `CPT_ADDR_MASK: rdMux = {31'h0, mask_q};
            default: rdHit = 1'h0;
        endcase
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rvalid <= 1'h0;
            rdata <= 32'h0;
            rresp <= `CPT_RESP_OKAY;
        end else if (rdFire) begin
            rvalid <= 1'h1;
            rdata <= rdMux;
            rresp <= rdHit ? `CPT_RESP_OKAY : `CPT_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'h0;
        end
    end

    assign tbIf.sel = ctrlReg[`CPT_BIT_TB_HI:`CPT_BIT_TB_LO];
    assign tbIf.run = pwr_q != cpt_pkg::PWR_HALT;
    assign tick = tbIf.tick;

    cpt_timebase_counter #(
        .TB_PERIOD0(TB_PERIOD0),
        .TB_PERIOD1(TB_PERIOD1),
        .TB_PERIOD2(TB_PERIOD2),
        .TB_PERIOD3(TB_PERIOD3)
    ) uCounter (
        .clk(mclk),
        .rstN(rstN),
        .tb(tbIf.cnt)
    );

    cpt_cpu_divider uDivider (
        .clk(mclk),
        .rstN(rstN),
        .run(!freezeReg),
        .slowSel(ctrlReg[`CPT_BIT_SLOW]),
        .divSel(ctrlReg[`CPT_BIT_DIV_HI:`CPT_BIT_DIV_LO]),
        .cpuClkEn(cpuClkEn)
    );

    // oscillator clock replaces the port function of the pin
    assign clkOutPinO = ctrlReg[`CPT_BIT_CLKOUT] ? mclk : gpioO;
    assign clkOutPinOe = ctrlReg[`CPT_BIT_CLKOUT] || gpioOe;

    chk_reset_clear: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(rstN) |-> ctrlReg == 8'h00)
        else $error("control register not clear after reset");

    chk_clkout_pin: assert property (
        @(posedge mclk) disable iff (!rstN)
        ctrlReg[`CPT_BIT_CLKOUT] |-> (clkOutPinOe && clkOutPinO == mclk))
        else $error("clock-out pin not driven");

    chk_flag_set: assert property (
        @(posedge mclk) disable iff (!rstN)
        tick |=> flag_q && evt_q)
        else $error("period end did not set the flag");

    chk_flag_clear: assert property (
        @(posedge mclk) disable iff (!rstN)
        (rdCtrl && !tick && !freezeReg) |=> !flag_q)
        else $error("control read did not clear the flag");

    chk_tb_irq: assert property (
        @(posedge mclk) disable iff (!rstN)
        (tick && ctrlReg[`CPT_BIT_IRQEN] && !wrCtrl) |=> tbIrq)
        else $error("time-base interrupt not raised");

    chk_active_halt: assert property (
        @(posedge mclk) disable iff (!rstN)
        (pwr_q == cpt_pkg::PWR_RUN && haltExec) |=>
        (activeHalt == $past(ctrlReg[`CPT_BIT_IRQEN]) &&
         haltMode == !$past(ctrlReg[`CPT_BIT_IRQEN])))
        else $error("halt entered the wrong mode");

    chk_halt_frozen: assert property (
        @(posedge mclk) disable iff (!rstN)
        (haltMode && $past(haltMode) && $past(haltMode, 2)) |->
        ($stable(ctrlReg) && !tick))
        else $error("register or counter moved in halt");

    chk_ahalt_wake: assert property (
        @(posedge mclk) disable iff (!rstN)
        (activeHalt && tbIrq) |=> pwr_q == cpt_pkg::PWR_RUN)
        else $error("time-base interrupt did not end active halt");
endmodule

// [verif/cpt_clock_timebase_test.sv]
/*
 * Self-checking bench for the clock and time-base unit: register access,
 * CPU clock divider, clock-out pin, time base, interrupts, power modes.
 * Assumes the design sources and cpt_defs.svh are compiled beforehand.
 */
`timescale 1ns/1ps
`include "cpt_defs.svh"
module cpt_clock_timebase_test;
    localparam logic [31:0] PER [4] = '{32'h00003E80, 32'h00000020,
        32'h00000050, 32'h000000C8};
    localparam logic [9:0] CTRL = `CPT_ADDR_CTRL;
    localparam logic [9:0] STAT = `CPT_ADDR_STAT;
    localparam logic [9:0] MASK = `CPT_ADDR_MASK;
    localparam logic [1:0] OK = `CPT_RESP_OKAY;
    localparam logic [1:0] ERR = `CPT_RESP_SLVERR;
    logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic [9:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    logic haltExec, waitExec, wakeExt, gpioO, gpioOe;
    logic clkOutPinO, clkOutPinOe, cpuClkEn, tbIrq, irq, activeHalt;
    logic haltMode;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int t, t2, g, n;

    cpt_clock_timebase #(.TB_PERIOD1(PER[1][17:0]),
        .TB_PERIOD2(PER[2][17:0]), .TB_PERIOD3(PER[3][17:0]))
    u_cpt_clock_timebase (.mclk(mclk), .nrst(nrst), .awaddr(awaddr),
        .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .haltExec(haltExec),
        .waitExec(waitExec), .wakeExt(wakeExt), .gpioO(gpioO),
        .gpioOe(gpioOe), .clkOutPinO(clkOutPinO),
        .clkOutPinOe(clkOutPinOe), .cpuClkEn(cpuClkEn), .tbIrq(tbIrq),
        .irq(irq), .activeHalt(activeHalt), .haltMode(haltMode));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) cyc <= cyc + 1;

    task automatic conclude;
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask

    // whole-byte writes only, never a read-modify-write of one bit
    task automatic wr(input logic [9:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge mclk);
        while (awready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge mclk);
        while (bvalid !== 1'b1) @(negedge mclk);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        @(posedge mclk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er,
                      input string nm);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge mclk);
        while (arready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        arvalid <= 1'b0;
        @(negedge mclk);
        while (rvalid !== 1'b1) @(negedge mclk);
        chk(nm, e & m, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge mclk);
        rready <= 1'b0;
    endtask

    task automatic wait_tick(output int tt);
        int k;
        k = 0;
        @(negedge mclk);
        while (tbIrq !== 1'b1 && k < 17000) begin
            k++;
            @(negedge mclk);
        end
        tt = cyc;
        rd(CTRL, 32'h1, 32'h1, OK, "flag set");
        @(negedge mclk);
        chk("irq after read", 32'h0, {31'h0, tbIrq});
    endtask

    task automatic meas_gap(output int gg);
        repeat (20) @(negedge mclk);
        while (cpuClkEn !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        gg = 1;
        while (cpuClkEn !== 1'b1 && gg < 40) begin
            gg++;
            @(negedge mclk);
        end
    endtask

    task automatic pulse_halt;
        @(posedge mclk);
        haltExec <= 1'b1;
        @(posedge mclk);
        haltExec <= 1'b0;
        // the enable is registered, so it stops one cycle after entry
        repeat (2) @(negedge mclk);
        chk("cpu clock stopped", 32'h0, {31'h0, cpuClkEn});
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {haltExec, waitExec, wakeExt, gpioO, gpioOe} = 5'h00;
        awaddr = 10'h000;
        araddr = 10'h000;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(CTRL, 32'h0, 32'hFFFFFFFF, OK, "ctrl reset");
        rd(STAT, 32'h0, 32'hFFFFFFFF, OK, "status reset");
        rd(MASK, 32'h0, 32'hFFFFFFFF, OK, "mask reset");
        rd(10'h3FC, 32'h0, 32'hFFFFFFFF, ERR, "unmapped read");
        wr(10'h3FC, 8'hFF, ERR);
        wr(STAT, 8'h01, ERR);
        meas_gap(g);
        chk("cpu gap normal", 32'h1, g);
        for (int i = 0; i < 4; i++) begin
            wr(CTRL, {1'b0, i[1:0], 5'h10}, OK);
            meas_gap(g);
            chk("cpu gap slow", 32'(2 << i), g);
        end
        wr(CTRL, 8'h60, OK);
        meas_gap(g);
        chk("cpu gap slow off", 32'h1, g);
        wr(CTRL, 8'h80, OK);
        gpioO <= 1'b1;
        // let the pin mux follow the falling clock before looking
        @(negedge mclk);
        #1;
        chk("pin enable", 32'h1, {31'h0, clkOutPinOe});
        chk("pin low", 32'h0, {31'h0, clkOutPinO});
        @(posedge mclk);
        #1;
        chk("pin high", 32'h1, {31'h0, clkOutPinO});
        wr(CTRL, 8'h00, OK);
        @(negedge mclk);
        chk("pin gpio value", 32'h1, {31'h0, clkOutPinO});
        chk("pin gpio enable", 32'h0, {31'h0, clkOutPinOe});
        @(posedge mclk);
        gpioOe <= 1'b1;
        @(negedge mclk);
        chk("pin gpio enable on", 32'h1, {31'h0, clkOutPinOe});
        @(posedge mclk);
        gpioOe <= 1'b0;
        wr(MASK, 8'h01, OK);
        wr(CTRL, 8'h06, OK);
        wait_tick(t);
        chk("first period", 32'h1,
            {31'h0, t >= 16000 && t <= 16012});
        wait_tick(t2);
        chk("period", PER[1], t2 - t);
        for (int i = 2; i < 4; i++) begin
            wr(CTRL, {4'h0, i[1:0], 2'h2}, OK);
            wait_tick(t);
            chk("old period kept", PER[i - 1], t - t2);
            wait_tick(t2);
            chk("new period", PER[i], t2 - t);
        end
        rd(STAT, 32'h1, 32'hFFFFFFFF, OK, "status set");
        @(negedge mclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(MASK, 8'h00, OK);
        wait_tick(t);
        chk("irq masked", 32'h0, {31'h0, irq});
        pulse_halt();
        chk("active halt", 32'h1, {31'h0, activeHalt});
        chk("no full halt", 32'h0, {31'h0, haltMode});
        wr(CTRL, 8'h80, OK);
        rd(CTRL, 32'h0E, 32'hFE, OK, "ctrl frozen");
        wait_tick(t2);
        chk("period in active halt", PER[3], t2 - t);
        chk("woken from active halt", 32'h0, {31'h0, activeHalt});
        wr(CTRL, 8'h0C, OK);
        wr(MASK, 8'h01, OK);
        rd(STAT, 32'h1, 32'hFFFFFFFF, OK, "status sticky");
        pulse_halt();
        chk("full halt", 32'h1, {31'h0, haltMode});
        n = 0;
        repeat (450) begin
            @(negedge mclk);
            if (irq !== 1'b0 || haltMode !== 1'b1)
                n++;
        end
        chk("halt frozen", 32'h0, n);
        @(posedge mclk);
        wakeExt <= 1'b1;
        repeat (5) @(negedge mclk);
        chk("woken from halt", 32'h0, {31'h0, haltMode});
        @(posedge mclk);
        wakeExt <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 210) begin
            n++;
            @(negedge mclk);
        end
        t2 = cyc;
        chk("counter resumed", 32'h1, {31'h0, irq});
        chk("tb irq disabled", 32'h0, {31'h0, tbIrq});
        rd(CTRL, 32'h0D, 32'hFF, OK, "flag without enable");
        rd(STAT, 32'h1, 32'hFFFFFFFF, OK, "status after halt");
        wr(CTRL, 8'h0E, OK);
        @(posedge mclk);
        waitExec <= 1'b1;
        @(posedge mclk);
        waitExec <= 1'b0;
        repeat (3) @(negedge mclk);
        chk("cpu clock in wait", 32'h1, {31'h0, cpuClkEn});
        chk("no irq in wait", 32'h0, {31'h0, tbIrq});
        wait_tick(t);
        chk("period in wait", PER[3], t - t2);
        conclude();
    end
endmodule
